/* pkg/cftmb_pkg.sv */
// How it works
// RULE_01 - Setting boost-off bit disables boost and clears dynamic acceleration capability.
// RULE_02 - Boost-off bit clear on capable part reports boost enabled.
// RULE_03 - Boost-off bit resets to 1 when boost hardware exists, else 0.
// RULE_04 - Thermal target bits 23:16 read back the fixed default temperature.
// RULE_05 - Overheat and throttle start at default target plus offset.
// RULE_06 - Thermal target bits 29:24 hold a writable offset in degrees.
// RULE_07 - Boost ratio ceiling holds eight byte fields, one per active core count.
// RULE_08 - Feature bits 7, 11 and 12 are read-only status.
// RULE_09 - Feature bits 0,3,16,18,22,23,34 are software read/write controls.
// RULE_10 - Two independent read/write uncore response selects at consecutive indices.
// RULE_11 - Thermal irq control and monitor status are read/write, consecutive.
// RULE_12 - Clock duty modulation sits just below thermal irq control, read/write.
// RULE_13 - Reserved bits read zero and writes to them are dropped.
`default_nettype none
package cftmb_pkg;
	// Register indices; byte address of low word is four times the index
	localparam logic [12:0] IDX_DUTY_MOD = 13'h019A;
	localparam logic [12:0] IDX_IRQ_CTL = 13'h019B;
	localparam logic [12:0] IDX_THERM_STAT = 13'h019C;
	localparam logic [12:0] IDX_MISC_EN = 13'h01A0;
	localparam logic [12:0] IDX_HOT_TARGET = 13'h01A2;
	localparam logic [12:0] IDX_RSP_SEL0 = 13'h01A6;
	localparam logic [12:0] IDX_RSP_SEL1 = 13'h01A7;
	localparam logic [12:0] IDX_RATIO_CEIL = 13'h01AD;
	// Upper 32 bits of each register are mirrored at this byte offset
	localparam logic [12:0] HI_BASE = 13'h1000;
	localparam int ADDR_W = 13;

	localparam logic [2:0] SLOT_DUTY = 3'h0;
	localparam logic [2:0] SLOT_IRQ = 3'h1;
	localparam logic [2:0] SLOT_STAT = 3'h2;
	localparam logic [2:0] SLOT_MISC = 3'h3;
	localparam logic [2:0] SLOT_TARGET = 3'h4;
	localparam logic [2:0] SLOT_RSP0 = 3'h5;
	localparam logic [2:0] SLOT_RSP1 = 3'h6;
	localparam logic [2:0] SLOT_RATIO = 3'h7;
	localparam int SLOTS = 8;

	// Feature-enable bit positions
	localparam int MISC_FAST_STR = 0;
	localparam int MISC_AUTO_THERM = 3;
	localparam int MISC_PERF_AVAIL = 7;
	localparam int MISC_BTS_UNAVAIL = 11;
	localparam int MISC_PEBS_UNAVAIL = 12;
	localparam int MISC_SPEED_STEP = 16;
	localparam int MISC_MON_FSM = 18;
	localparam int MISC_LEAF_LIMIT = 22;
	localparam int MISC_TPR_OFF = 23;
	localparam int MISC_XD_OFF = 34;
	localparam int MISC_BOOST_OFF = 38;
	localparam logic [63:0] MISC_RW_MASK = 64'h0000_0044_00C5_0009;

	// Thermal target fields
	localparam int TGT_LSB = 16;
	localparam int OFS_LSB = 24;
	localparam int OFS_W = 6;
	localparam logic [63:0] TARGET_RW_MASK = 64'h0000_0000_3F00_0000;
	localparam logic [63:0] ALL_RW_MASK = 64'hFFFF_FFFF_FFFF_FFFF;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic hit;
		logic hi;
		logic [2:0] slot;
	} cftmb_dec_t;

	typedef struct packed {
		logic fast_strings;
		logic auto_thermal;
		logic speed_step;
		logic monitor_state_machine_enable;
		logic max_leaf_limit;
		logic task_priority_message_off;
		logic execute_disable_off;
		logic boost_off;
	} cftmb_ctl_t;
endpackage
`default_nettype wire

/* rtl/cftmb_bank.sv */
`default_nettype none
module cftmb_bank #(
	parameter logic [7:0] DEFAULT_TARGET = 8'h64,
	parameter logic BOOST_HW = 1'b1,
	parameter logic PERFMON_AVAIL = 1'b1,
	parameter logic BTS_UNAVAIL = 1'b0,
	parameter logic PEBS_UNAVAIL = 1'b0
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [cftmb_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [cftmb_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Thermal sensor reading, asynchronous
	input wire logic [7:0] core_temp,
	// Block outputs
	output cftmb_pkg::cftmb_ctl_t feature_ctl,
	output logic dynamic_accel_capability,
	output logic overheat_signal,
	output logic throttle,
	output logic [63:0] boost_ratio_ceiling
);
	import cftmb_pkg::*;

	if (DEFAULT_TARGET == 8'h00) begin : g_chk
		$error("DEFAULT_TARGET must be a nonzero temperature");
	end

	// The high-word window must sit above every low-word address
	if (HI_BASE <= {IDX_RATIO_CEIL[ADDR_W-3:0], 2'h0}) begin : g_win
		$error("high-word window overlaps the low-word map");
	end

	logic [63:0] regs_q [SLOTS];
	logic [63:0] regs_d [SLOTS];
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic [7:0] t1_q, t2_q, t3_q, temp_q, temp_d;
	logic [7:0] t1_d, t2_d, t3_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic hot_q, hot_d, accel_q, accel_d;

	function automatic cftmb_dec_t decode(input logic [ADDR_W-1:0] a);
		cftmb_dec_t r;
		logic [ADDR_W-1:0] idx;
		r.hi = (a >= HI_BASE);
		idx = r.hi ? (a - HI_BASE) >> 2 : a >> 2;
		r.hit = (a[1:0] == 2'h0);
		r.slot = SLOT_DUTY;
		case (idx)
			IDX_DUTY_MOD: r.slot = SLOT_DUTY; // RULE_12
			IDX_IRQ_CTL: r.slot = SLOT_IRQ; // RULE_11
			IDX_THERM_STAT: r.slot = SLOT_STAT; // RULE_11
			IDX_MISC_EN: r.slot = SLOT_MISC;
			IDX_HOT_TARGET: r.slot = SLOT_TARGET;
			IDX_RSP_SEL0: r.slot = SLOT_RSP0; // RULE_10
			IDX_RSP_SEL1: r.slot = SLOT_RSP1; // RULE_10
			IDX_RATIO_CEIL: r.slot = SLOT_RATIO; // RULE_07
			default: r.hit = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic [63:0] wmask(input logic [2:0] s);
		case (s)
			SLOT_MISC: return MISC_RW_MASK; // RULE_08 RULE_09 RULE_13
			SLOT_TARGET: return TARGET_RW_MASK; // RULE_06 RULE_13
			default: return ALL_RW_MASK;
		endcase
	endfunction

	// Read view adds the constant fields that never live in storage
	function automatic logic [63:0] rview(input logic [2:0] s,
		input logic [63:0] v);
		logic [63:0] r;
		r = v;
		if (s == SLOT_MISC) begin
			r[MISC_PERF_AVAIL] = PERFMON_AVAIL; // RULE_08
			r[MISC_BTS_UNAVAIL] = BTS_UNAVAIL; // RULE_08
			r[MISC_PEBS_UNAVAIL] = PEBS_UNAVAIL; // RULE_08
		end
		if (s == SLOT_TARGET) begin
			r[TGT_LSB +: 8] = DEFAULT_TARGET; // RULE_04
		end
		return r;
	endfunction

	cftmb_dec_t wdec, rdec;
	logic [63:0] cur, merged, rv;

	always_comb begin
		for (int i = 0; i < SLOTS; i++) begin
			regs_d[i] = regs_q[i];
		end
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		wdec = decode(aw_addr_q);
		cur = regs_q[wdec.slot];
		merged = cur;

		if (awvalid && !aw_full_q) begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && !w_full_q) begin
			w_full_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (bvalid_q && bready) begin
			bvalid_d = 1'b0;
		end
		// Commit only once the previous response has been taken
		if (aw_full_q && w_full_q && !bvalid_q) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb_q[b]) begin
					if (wdec.hi) begin
						merged[32 + 8*b +: 8] = w_data_q[8*b +: 8];
					end else begin
						merged[8*b +: 8] = w_data_q[8*b +: 8];
					end
				end
			end
			if (wdec.hit) begin
				regs_d[wdec.slot] = merged & wmask(wdec.slot); // RULE_13
			end
			bresp_d = wdec.hit ? RESP_OKAY : RESP_SLVERR;
			bvalid_d = 1'b1;
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
		end

		// Ready flags live in their own flops so the ports stay registered
		awready_d = !aw_full_d;
		wready_d = !w_full_d;
	end

	// Read channel: one read in flight, answered one edge after it is taken
	always_comb begin
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		rdec = decode(araddr);
		rv = rview(rdec.slot, regs_q[rdec.slot]);
		if (rvalid_q && rready) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		if (arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = rdec.hit ? RESP_OKAY : RESP_SLVERR;
			if (!rdec.hit) begin
				rdata_d = 32'h0000_0000;
			end else if (rdec.hi) begin
				rdata_d = rv[63:32];
			end else begin
				rdata_d = rv[31:0];
			end
		end
	end

	// Thermal compare; the offset raises the trip point above default
	logic [8:0] trip;
	always_comb begin
		trip = {1'b0, DEFAULT_TARGET} +
			{3'h0, regs_q[SLOT_TARGET][OFS_LSB +: OFS_W]}; // RULE_05
		t1_d = core_temp;
		t2_d = t1_q;
		t3_d = t2_q;
		// Multi-bit sample is used only when two stages agree
		temp_d = (t2_q == t3_q) ? t3_q : temp_q;
		hot_d = ({1'b0, temp_q} >= trip); // RULE_05
		accel_d = BOOST_HW && !regs_q[SLOT_MISC][MISC_BOOST_OFF]; // RULE_01 RULE_02
	end

	// Register storage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < SLOTS; i++) begin
				regs_q[i] <= 64'h0000_0000_0000_0000;
			end
			// Firmware reads this bit after power-on to learn if boost exists
			regs_q[SLOT_MISC][MISC_BOOST_OFF] <= BOOST_HW; // RULE_03
		end else begin
			for (int i = 0; i < SLOTS; i++) begin
				regs_q[i] <= regs_d[i];
			end
		end
	end

	// Write channel state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			awready_q <= 1'b1;
			aw_addr_q <= '0;
			w_full_q <= 1'b0;
			wready_q <= 1'b1;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			aw_full_q <= aw_full_d;
			awready_q <= awready_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			wready_q <= wready_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// Read channel state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else begin
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	// Temperature synchroniser, trip flag and capability flag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t1_q <= 8'h00;
			t2_q <= 8'h00;
			t3_q <= 8'h00;
			temp_q <= 8'h00;
			hot_q <= 1'b0;
			accel_q <= 1'b0;
		end else begin
			t1_q <= t1_d;
			t2_q <= t2_d;
			t3_q <= t3_d;
			temp_q <= temp_d;
			hot_q <= hot_d;
			accel_q <= accel_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;
	assign overheat_signal = hot_q; // RULE_05
	assign throttle = hot_q;
	assign dynamic_accel_capability = accel_q; // RULE_01 RULE_02
	assign boost_ratio_ceiling = regs_q[SLOT_RATIO]; // RULE_07
	assign feature_ctl = '{
		fast_strings: regs_q[SLOT_MISC][MISC_FAST_STR],
		auto_thermal: regs_q[SLOT_MISC][MISC_AUTO_THERM],
		speed_step: regs_q[SLOT_MISC][MISC_SPEED_STEP],
		monitor_state_machine_enable: regs_q[SLOT_MISC][MISC_MON_FSM],
		max_leaf_limit: regs_q[SLOT_MISC][MISC_LEAF_LIMIT],
		task_priority_message_off: regs_q[SLOT_MISC][MISC_TPR_OFF],
		execute_disable_off: regs_q[SLOT_MISC][MISC_XD_OFF],
		boost_off: regs_q[SLOT_MISC][MISC_BOOST_OFF]
	}; // RULE_09
endmodule
`default_nettype wire

/* sim/cftmb_monitor.sv */
`default_nettype none
module cftmb_monitor #(
	parameter logic BOOST_HW = 1'b1
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	// Block outputs
	input wire cftmb_pkg::cftmb_ctl_t feature_ctl,
	input wire logic dynamic_accel_capability,
	input wire logic overheat_signal,
	input wire logic throttle,
	input wire logic [63:0] boost_ratio_ceiling
);
	timeunit 1ns;
	timeprecision 1ps;
	import cftmb_pkg::*;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	boost_off_a: assert property (
		feature_ctl.boost_off |=> !dynamic_accel_capability)
		else $error("capability shown while boost is off");
	boost_on_a: assert property (
		BOOST_HW && !feature_ctl.boost_off |=> dynamic_accel_capability)
		else $error("capability missing while boost is on");
	boost_reset_a: assert property (
		$rose(aresetn) |-> feature_ctl.boost_off == BOOST_HW)
		else $error("boost-off reset value wrong");
	throttle_eq_a: assert property (
		throttle == overheat_signal)
		else $error("throttle differs from overheat");
	// Stored state may only move at a write commit
	ratio_hold_a: assert property (
		$changed(boost_ratio_ceiling) |-> !$past(awready))
		else $error("ratio ceiling changed without a write");
	ctl_hold_a: assert property (
		$changed(feature_ctl) |-> !$past(awready))
		else $error("feature controls changed without a write");
	read_answer_a: assert property (
		arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	write_answer_a: assert property (
		awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write response late");
endmodule
bind cftmb_bank cftmb_monitor #(.BOOST_HW(BOOST_HW)) cftmb_monitor_inst (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid,
	.arvalid, .arready, .rvalid, .feature_ctl, .dynamic_accel_capability,
	.overheat_signal, .throttle, .boost_ratio_ceiling);
`default_nettype wire

/* sim/cftmb_bank_tb.sv */
`default_nettype none
module cftmb_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cftmb_pkg::*;
	localparam logic [7:0] TGT = 8'h64;
	logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic dynamic_accel_capability, overheat_signal, throttle;
	logic [12:0] awaddr = 13'h0000, araddr = 13'h0000;
	logic [31:0] wdata = 32'h0, rdata, word;
	logic [1:0] bresp, rresp, rsp;
	logic [7:0] core_temp = 8'h00;
	logic [63:0] boost_ratio_ceiling, v;
	cftmb_ctl_t feature_ctl;
	int mismatches = 0, n_compared = 0;
	logic [12:0] rw [6] = '{IDX_DUTY_MOD, IDX_IRQ_CTL, IDX_THERM_STAT,
		IDX_RSP_SEL0, IDX_RSP_SEL1, IDX_RATIO_CEIL};
	always #2 aclk = ~aclk;
	cftmb_bank #(.DEFAULT_TARGET(TGT)) cftmb_bank_inst (
		.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
		.wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
		.arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready,
		.rdata, .rresp, .core_temp, .feature_ctl, .dynamic_accel_capability,
		.overheat_signal, .throttle, .boost_ratio_ceiling);
	function automatic logic [63:0] pat(input logic [12:0] i);
		return {19'h5A5A5, i, 19'h3C3C3, i};
	endfunction
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [12:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rsp = rresp;
		word = rdata;
		rready <= 1'b0;
	endtask
	task automatic w64(input logic [12:0] i, input logic [63:0] d);
		wr({i[10:0], 2'h0}, d[31:0]);
		wr(HI_BASE + {i[10:0], 2'h0}, d[63:32]);
	endtask
	task automatic r64(input logic [12:0] i, input logic [63:0] e);
		rd({i[10:0], 2'h0});
		v[31:0] = word;
		rd(HI_BASE + {i[10:0], 2'h0});
		v[63:32] = word;
		chk(v, e);
	endtask
	task automatic finish_test;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		mismatches++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		r64(IDX_MISC_EN, 64'h0000_0040_0000_0080);
		chk(dynamic_accel_capability, 64'h0);
		w64(IDX_MISC_EN, 64'hFFFF_FFFF_FFFF_FFFF);
		r64(IDX_MISC_EN, MISC_RW_MASK | 64'h80);
		chk(feature_ctl, 64'hFF);
		chk(dynamic_accel_capability, 64'h0);
		w64(IDX_MISC_EN, 64'h0);
		r64(IDX_MISC_EN, 64'h80);
		chk(dynamic_accel_capability, 64'h1);
		w64(IDX_HOT_TARGET, 64'hFFFF_FFFF_FFFF_FFFF);
		r64(IDX_HOT_TARGET, TARGET_RW_MASK | {40'h0, TGT, 16'h0});
		// Offset of 5 degrees; walk down across the trip point
		wr({IDX_HOT_TARGET[10:0], 2'h0}, 32'h0500_0000);
		r64(IDX_HOT_TARGET, {32'h0, 8'h05, TGT, 16'h0});
		for (int k = 6; k > 3; k--) begin
			core_temp <= TGT + 8'(k);
			repeat (10) @(posedge aclk);
			chk(overheat_signal, 64'(k > 4));
			chk(throttle, 64'(k > 4));
		end
		foreach (rw[i]) w64(rw[i], pat(rw[i]));
		foreach (rw[i]) r64(rw[i], pat(rw[i]));
		chk(boost_ratio_ceiling, pat(IDX_RATIO_CEIL));
		wr(13'h0684, 32'hFFFF_FFFF);
		chk(rsp, RESP_SLVERR);
		rd(13'h0684);
		chk({rsp, word}, {RESP_SLVERR, 32'h0});
		wr(13'h0681, 32'hFFFF_FFFF);
		chk(rsp, RESP_SLVERR);
		r64(IDX_MISC_EN, 64'h80);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		r64(IDX_MISC_EN, 64'h0000_0040_0000_0080);
		r64(IDX_RATIO_CEIL, 64'h0);
		finish_test();
	end
endmodule
`default_nettype wire
